// [rtl/sleep_power_ctrl.sv]
// sleep mode control, brown-out sleep sequence and per-module clock gating
//
// Design decisions made here: the register offsets and the strobed register port.
`default_nettype none

// Contract
// RL1: sleep control bits 7..3 read as zero and ignore writes.
// RL2: mode field bits 2..1: 00 idle, 01 noise reduce, 10 down, 11 save.
// RL3: sleep request only takes effect while sleep enable bit is one.
// RL4: brown-out sleep bit set only by enable write then timed write within four.
// RL5: brown-out sleep bit active three cycles after set, cleared three later.
// RL6: brown-out detector off in sleep only if sleep entered while bit active.
// RL7: enabled converter stays enabled in every sleep mode.
// RL8: comparator auto-off in power-down and power-save, else software decides; code keeps it on there while it uses the reference.
// RL9: comparator using the reference keeps the reference on in any mode.
// RL10: fuse-enabled brown-out detector stays on in all sleep modes; code turns it off in a sleep entered while brown-out sleep is active (RL6).
// RL11: enabled watchdog keeps running in all sleep modes.
// RL12: reference on only while detector, comparator or converter needs it.
// RL13: input buffers off when io and converter clocks both stop, except wake pins.
// RL14: debug fuse keeps main clock source running in every sleep mode.
// RL15: power reduction bits 7 and 6 read as zero.
// RL16: bit 5 stops the lin/uart clock.
// RL17: bit 4 stops the serial peripheral clock.
// RL18: bit 3 shuts down the sixteen-bit timer, resuming its state.
// RL19: bit 2 shuts down eight-bit timer only in synchronous mode.
// RL20: bit 1 stops the universal serial interface clock.
// RL21: bit 0 shuts down converter; comparator loses converter multiplexer.
// RL22: gated module state frozen, its registers blocked, restored on clear.
// RL23: each clock gate switches glitch-free.
module sleep_power_ctrl
    import sleep_power_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire sleep_power_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // core handshake
    input wire logic sleep_instr,
    input wire logic wake_event,
    // fuses and peripheral configuration
    input wire sleep_power_pkg::cfg_in_t cfg,
    input wire logic [NUM_PINS-1:0] wake_pin_mask,
    // power and clock controls
    output sleep_power_pkg::power_out_t pwr,
    output logic [NUM_GATES-1:0] module_clock_en,
    output logic [NUM_GATES-1:0] module_io_block,
    output logic comp_mux_allowed,
    output logic [NUM_PINS-1:0] pin_buffer_en
);
    import sleep_power_pkg::*;

    logic sleep_enable_bit;
    sleep_mode_t sleep_mode_select;
    logic [7:0] module_power_reduction;
    logic brownout_sleep_write_enable;
    logic brownout_sleep_bit;
    logic [2:0] window_cnt;
    logic [2:0] bo_sleep_cnt;
    logic bo_sleep_active;
    logic asleep;
    sleep_mode_t active_mode;
    logic bod_off_in_sleep;
    logic [NUM_GATES-1:0] gate_req;
    logic next_ref_on;
    logic io_clk_run;
    logic adc_clk_run;

    function automatic logic is_deep(input sleep_mode_t m);
        is_deep = (m == MODE_POWER_DOWN) || (m == MODE_POWER_SAVE);
    endfunction

    function automatic logic is_reg(input logic [1:0] a, input logic [1:0] target);
        is_reg = (a == target);
    endfunction

    // sleep mode control register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sleep_enable_bit <= SLEEP_MODE_CONTROL_RESET[SLEEP_ENABLE_POS];
            sleep_mode_select <= MODE_IDLE;
        end else if (req.wr && is_reg(req.addr, ADDR_SLEEP_MODE_CONTROL)) begin
            sleep_enable_bit <= req.wdata[SLEEP_ENABLE_POS]; // RL3
            sleep_mode_select <= sleep_mode_t'(req.wdata[SLEEP_MODE_MSB:SLEEP_MODE_LSB]); // RL2
        end
    end

    // module power reduction register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            module_power_reduction <= MODULE_POWER_REDUCTION_RESET;
        end else if (req.wr && is_reg(req.addr, ADDR_MODULE_POWER_REDUCTION)) begin
            module_power_reduction <= req.wdata & MODULE_POWER_REDUCTION_MASK; // RL15
        end
    end

    // timed brown-out sleep sequence: enable write opens a four-cycle window
    always_ff @(posedge core_clk) begin
        if (srst) begin
            brownout_sleep_write_enable <= 1'b0;
            window_cnt <= 3'h0;
        end else if (req.wr && is_reg(req.addr, ADDR_CORE_CONTROL)
                     && req.wdata[BROWNOUT_SLEEP_WE_POS] && req.wdata[BROWNOUT_SLEEP_POS]) begin
            brownout_sleep_write_enable <= 1'b1; // RL4
            window_cnt <= BO_SLEEP_WINDOW_CYCLES;
        end else if (req.wr && is_reg(req.addr, ADDR_CORE_CONTROL)) begin
            brownout_sleep_write_enable <= 1'b0;
            window_cnt <= 3'h0;
        end else if (window_cnt != 3'h0) begin
            window_cnt <= window_cnt - 3'h1;
            if (window_cnt == 3'h1) begin
                brownout_sleep_write_enable <= 1'b0;
            end
        end
    end

    // bit set on the timed write, active after three cycles, cleared three later
    always_ff @(posedge core_clk) begin
        if (srst) begin
            brownout_sleep_bit <= 1'b0;
            bo_sleep_cnt <= 3'h0;
            bo_sleep_active <= 1'b0;
        end else if (req.wr && is_reg(req.addr, ADDR_CORE_CONTROL) && window_cnt != 3'h0
                     && req.wdata[BROWNOUT_SLEEP_POS] && !req.wdata[BROWNOUT_SLEEP_WE_POS]) begin
            brownout_sleep_bit <= 1'b1; // RL4
            // the edge that raises active counts as the last of the delay
            bo_sleep_cnt <= BO_SLEEP_ACTIVE_DELAY - 3'h1;
            bo_sleep_active <= 1'b0;
        end else if (brownout_sleep_bit) begin
            if (bo_sleep_cnt != 3'h0) begin
                bo_sleep_cnt <= bo_sleep_cnt - 3'h1;
            end else if (!bo_sleep_active) begin
                bo_sleep_active <= 1'b1; // RL5
                bo_sleep_cnt <= BO_SLEEP_ACTIVE_HOLD - 3'h1;
            end else begin
                bo_sleep_active <= 1'b0; // RL5
                brownout_sleep_bit <= 1'b0;
            end
        end
    end

    // sleep entry and wake; a wake in the entry cycle still wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            asleep <= 1'b0;
            active_mode <= MODE_IDLE;
            bod_off_in_sleep <= 1'b0;
        end else if (wake_event) begin
            asleep <= 1'b0;
            bod_off_in_sleep <= 1'b0;
        end else if (sleep_instr && sleep_enable_bit && !asleep) begin
            asleep <= 1'b1; // RL3
            active_mode <= sleep_mode_select;
            bod_off_in_sleep <= bo_sleep_active; // RL6
        end
    end

    // glitch-free gating: request toggles only on a clock edge, so an
    // enable latched low externally yields whole pulses only
    always_comb begin
        gate_req = module_power_reduction[NUM_GATES-1:0]; // RL16 RL17 RL18 RL20 RL21
        gate_req[GATE_TIMER_EIGHT_POS] = module_power_reduction[GATE_TIMER_EIGHT_POS]
            && !cfg.timer_eight_async_select; // RL19
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GATES; g++) begin : gen_gate
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    module_clock_en[g] <= 1'b1;
                    module_io_block[g] <= 1'b0;
                end else begin
                    module_clock_en[g] <= !gate_req[g]; // RL23
                    module_io_block[g] <= gate_req[g]; // RL22
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (srst) begin
            comp_mux_allowed <= 1'b1;
        end else begin
            comp_mux_allowed <= !module_power_reduction[GATE_CONVERTER_POS]; // RL21
        end
    end

    // clock domains per sleep mode
    always_comb begin
        io_clk_run = !asleep || (active_mode == MODE_IDLE);
        adc_clk_run = !asleep || !is_deep(active_mode);
        next_ref_on = (cfg.brownout_fuse_on && !(asleep && bod_off_in_sleep))
            || cfg.comp_uses_ref || cfg.adc_enabled; // RL9 RL12
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pwr <= '0;
            pin_buffer_en <= '0;
        end else begin
            pwr.core_stopped <= asleep;
            pwr.io_clock_on <= io_clk_run;
            pwr.converter_clock_on <= adc_clk_run;
            pwr.async_clock_on <= !asleep || (active_mode != MODE_POWER_DOWN);
            pwr.main_osc_on <= !asleep || !is_deep(active_mode) || cfg.debug_enable_fuse; // RL14
            pwr.brownout_on <= cfg.brownout_fuse_on && !(asleep && bod_off_in_sleep); // RL6 RL10
            pwr.comparator_on <= !cfg.comp_disabled
                && !(asleep && is_deep(active_mode) && !cfg.comp_uses_ref); // RL8 RL9
            pwr.adc_on <= cfg.adc_enabled && !module_power_reduction[GATE_CONVERTER_POS]; // RL7
            pwr.reference_on <= next_ref_on; // RL12
            pwr.watchdog_on <= cfg.watchdog_on; // RL11
            pwr.input_buffers_on <= io_clk_run || adc_clk_run;
            pin_buffer_en <= (io_clk_run || adc_clk_run) ? '1 : wake_pin_mask; // RL13
        end
    end

    // register read, data in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_SLEEP_MODE_CONTROL: begin
                    rdata <= {5'h00, sleep_mode_select, sleep_enable_bit}; // RL1
                end
                ADDR_CORE_CONTROL: begin
                    rdata <= 8'h00;
                    rdata[BROWNOUT_SLEEP_POS] <= brownout_sleep_bit;
                    rdata[BROWNOUT_SLEEP_WE_POS] <= brownout_sleep_write_enable;
                end
                ADDR_MODULE_POWER_REDUCTION: begin
                    rdata <= module_power_reduction & MODULE_POWER_REDUCTION_MASK; // RL15
                end
                ADDR_POWER_STATUS: begin
                    rdata <= 8'h00;
                    rdata[STAT_ASLEEP_POS] <= asleep;
                    rdata[STAT_BOD_OFF_POS] <= bod_off_in_sleep;
                    rdata[STAT_REF_ON_POS] <= next_ref_on;
                    rdata[STAT_ARMED_POS] <= bo_sleep_active;
                    rdata[STAT_SLEEP_BOD_POS] <= cfg.brownout_fuse_on;
                end
                default: begin
                    rdata <= 8'h00;
                end
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

`default_nettype wire

// [rtl/sleep_power_pkg.sv]
// constants and carrier types for the sleep and module power control block
package sleep_power_pkg;
    // register indices; the offsets are this block's own choice
    localparam logic [1:0] ADDR_SLEEP_MODE_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_CORE_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_MODULE_POWER_REDUCTION = 2'h2;
    localparam logic [1:0] ADDR_POWER_STATUS = 2'h3;

    // sleep mode control fields
    localparam int SLEEP_ENABLE_POS = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam int SLEEP_MODE_MSB = 2;
    localparam logic [7:0] SLEEP_MODE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SLEEP_MODE_CONTROL_MASK = 8'h07;

    // core control fields
    localparam int BROWNOUT_SLEEP_WE_POS = 5;
    localparam int BROWNOUT_SLEEP_POS = 6;

    // module power reduction fields
    localparam int GATE_CONVERTER_POS = 0;
    localparam int GATE_UNIVERSAL_SERIAL_POS = 1;
    localparam int GATE_TIMER_EIGHT_POS = 2;
    localparam int GATE_TIMER_SIXTEEN_POS = 3;
    localparam int GATE_SERIAL_PERIPH_POS = 4;
    localparam int GATE_LIN_UART_POS = 5;
    localparam int NUM_GATES = 6;
    localparam logic [7:0] MODULE_POWER_REDUCTION_RESET = 8'h00;
    localparam logic [7:0] MODULE_POWER_REDUCTION_MASK = 8'h3f;

    // status register fields
    localparam int STAT_ASLEEP_POS = 0;
    localparam int STAT_BOD_OFF_POS = 1;
    localparam int STAT_REF_ON_POS = 2;
    localparam int STAT_ARMED_POS = 3;
    localparam int STAT_SLEEP_BOD_POS = 4;

    // timed sequence figures in clock cycles
    localparam logic [2:0] BO_SLEEP_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] BO_SLEEP_ACTIVE_DELAY = 3'h3;
    localparam logic [2:0] BO_SLEEP_ACTIVE_HOLD = 3'h3;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_ADC_NOISE = 2'h1,
        MODE_POWER_DOWN = 2'h2,
        MODE_POWER_SAVE = 2'h3
    } sleep_mode_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic brownout_fuse_on;
        logic debug_enable_fuse;
        logic watchdog_on;
        logic adc_enabled;
        logic comp_disabled;
        logic comp_uses_ref;
        logic timer_eight_async_select;
    } cfg_in_t;

    typedef struct packed {
        logic core_stopped;
        logic io_clock_on;
        logic converter_clock_on;
        logic async_clock_on;
        logic main_osc_on;
        logic brownout_on;
        logic comparator_on;
        logic adc_on;
        logic reference_on;
        logic watchdog_on;
        logic input_buffers_on;
    } power_out_t;
endpackage

// [test/sleep_and_module_power_control_tb_top.sv]
// self-checking bench for the sleep and module power control block
`default_nettype none
module sleep_and_module_power_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_power_pkg::*;
    typedef struct {
        logic [1:0] mode;
        logic en;
        logic stop;
        logic comp;
        logic [3:0] clks;
        logic [7:0] bufs;
    } row_t;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic sleep_instr = 1'h0;
    logic wake_event = 1'h0;
    cfg_in_t cfg = 7'h78;
    logic [7:0] wake_pin_mask = 8'h81;
    power_out_t pwr;
    logic [5:0] module_clock_en;
    logic [5:0] module_io_block;
    logic comp_mux_allowed;
    logic [7:0] pin_buffer_en;
    int num_errors = 0;
    int checked = 0;
    int hits;
    // deep modes keep only the wake pins buffered; clks is io, converter, async, buffers
    row_t rows[5] = '{'{2'h0, 1'h1, 1'h1, 1'h1, 4'hf, 8'hff},
        '{2'h1, 1'h1, 1'h1, 1'h1, 4'h7, 8'hff},
        '{2'h2, 1'h1, 1'h1, 1'h0, 4'h0, 8'h81}, '{2'h3, 1'h1, 1'h1, 1'h0, 4'h2, 8'h81},
        '{2'h2, 1'h0, 1'h0, 1'h1, 4'hf, 8'hff}};
    sleep_power_ctrl dut (
        .core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata),
        .sleep_instr(sleep_instr), .wake_event(wake_event), .cfg(cfg),
        .wake_pin_mask(wake_pin_mask), .pwr(pwr), .module_clock_en(module_clock_en),
        .module_io_block(module_io_block), .comp_mux_allowed(comp_mux_allowed),
        .pin_buffer_en(pin_buffer_en));
    always #5 core_clk = ~core_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // inputs move just after the edge so no race with the sampling edge
    task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        req <= '{a, d, w, r};
        @(posedge core_clk);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'h0, 1'h0, 2'h0, 8'h00);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        bus(1'h0, 1'h1, a, 8'h00);
        check(rdata, exp);
    endtask
    task automatic pulse_wake();
        wake_event <= 1'h1;
        idle(1);
        wake_event <= 1'h0;
        idle(3);
    endtask
    // arm, then the timed write after gap idle cycles, then poll the status
    task automatic bod(input int gap, input logic slp);
        hits = 0;
        bus(1'h1, 1'h0, ADDR_CORE_CONTROL, 8'h60);
        idle(gap);
        bus(1'h1, 1'h0, ADDR_CORE_CONTROL, 8'h40);
        for (int i = 0; i < 8; i++) begin
            sleep_instr <= slp && i == 4;
            bus(1'h0, 1'h1, ADDR_POWER_STATUS, 8'h00);
            hits |= int'(rdata[STAT_ARMED_POS]) << i;
        end
        sleep_instr <= 1'h0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        srst <= 1'h0;
        idle(1);
        rd(ADDR_SLEEP_MODE_CONTROL, SLEEP_MODE_CONTROL_RESET);
        rd(ADDR_MODULE_POWER_REDUCTION, MODULE_POWER_REDUCTION_RESET);
        foreach (rows[i]) begin
            bus(1'h1, 1'h0, ADDR_SLEEP_MODE_CONTROL, {5'h1f, rows[i].mode, rows[i].en});
            rd(ADDR_SLEEP_MODE_CONTROL, {5'h00, rows[i].mode, rows[i].en});
            sleep_instr <= 1'h1;
            idle(1);
            sleep_instr <= 1'h0;
            idle(3);
            check(8'(pwr.core_stopped), 8'(rows[i].stop));
            check(8'(pwr.comparator_on), 8'(rows[i].comp));
            check(pin_buffer_en, rows[i].bufs);
            check({4'h0, pwr.io_clock_on, pwr.converter_clock_on, pwr.async_clock_on,
                pwr.input_buffers_on}, {4'h0, rows[i].clks});
            check({3'h0, pwr.adc_on, pwr.watchdog_on, pwr.brownout_on, pwr.main_osc_on,
                pwr.reference_on}, 8'h1f);
            pulse_wake();
        end
        $display("test sleep modes done");
        bus(1'h1, 1'h0, ADDR_SLEEP_MODE_CONTROL, 8'h05);
        bod(3, 1'h0);
        check(8'(hits), 8'h38);
        bod(4, 1'h0);
        check(8'(hits), 8'h00);
        bod(0, 1'h1);
        check(8'(pwr.brownout_on), 8'h00);
        pulse_wake();
        check(8'(pwr.brownout_on), 8'h01);
        $display("test brownout sleep done");
        // the converter must be disabled before its clock is gated, and the serial
        // peripheral may only be gated while the debug link is off
        cfg.adc_enabled <= 1'h0;
        cfg.debug_enable_fuse <= 1'h0;
        bus(1'h1, 1'h0, ADDR_MODULE_POWER_REDUCTION, 8'hff);
        rd(ADDR_MODULE_POWER_REDUCTION, 8'h3f);
        idle(2);
        check({2'h0, module_clock_en}, 8'h00);
        check({2'h0, module_io_block}, 8'h3f);
        check(8'(comp_mux_allowed), 8'h00);
        cfg.timer_eight_async_select <= 1'h1;
        bus(1'h1, 1'h0, ADDR_MODULE_POWER_REDUCTION, 8'h04);
        idle(2);
        check({2'h0, module_clock_en}, 8'h3f);
        cfg.timer_eight_async_select <= 1'h0;
        $display("test power reduction done");
        bus(1'h1, 1'h0, ADDR_MODULE_POWER_REDUCTION, 8'h3f);
        srst <= 1'h1;
        idle(2);
        srst <= 1'h0;
        idle(1);
        rd(ADDR_MODULE_POWER_REDUCTION, MODULE_POWER_REDUCTION_RESET);
        rd(ADDR_SLEEP_MODE_CONTROL, SLEEP_MODE_CONTROL_RESET);
        check({2'h0, module_clock_en}, 8'h3f);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire

// [test/sleep_power_chk.sv]
// assertion checker for the sleep and module power control block
`default_nettype none
module sleep_power_chk
    import sleep_power_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire sleep_power_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    // configuration
    input wire sleep_power_pkg::cfg_in_t cfg,
    input wire logic [NUM_PINS-1:0] wake_pin_mask,
    // controls
    input wire sleep_power_pkg::power_out_t pwr,
    input wire logic [NUM_GATES-1:0] module_clock_en,
    input wire logic [NUM_GATES-1:0] module_io_block,
    input wire logic comp_mux_allowed,
    input wire logic [NUM_PINS-1:0] pin_buffer_en
);
    // outputs lag reset by one edge, so that edge is skipped too
    logic rst_d;
    always_ff @(posedge core_clk) begin
        rst_d <= srst;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst || rst_d);
    sequence power_reduction_write;
        req.wr && req.addr == ADDR_MODULE_POWER_REDUCTION;
    endsequence
    sequence read_of(logic [1:0] a);
        $past(req.rd) && $past(req.addr) == a;
    endsequence
    rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    smc_res_a: assert property (read_of(ADDR_SLEEP_MODE_CONTROL) |-> rdata[7:3] == 5'h00)
        else $error("sleep control upper bits not zero");
    reduction_res_a: assert property (read_of(ADDR_MODULE_POWER_REDUCTION) |-> rdata[7:6] == 2'h0)
        else $error("power reduction upper bits not zero");
    lin_gate_a: assert property (power_reduction_write ##0 req.wdata[GATE_LIN_UART_POS]
        |-> ##[1:2] !module_clock_en[GATE_LIN_UART_POS]) else $error("uart clock not stopped");
    spi_gate_a: assert property (power_reduction_write ##0 req.wdata[GATE_SERIAL_PERIPH_POS]
        |-> ##[1:2] !module_clock_en[GATE_SERIAL_PERIPH_POS]) else $error("spi clock not stopped");
    io_block_a: assert property (module_io_block == ~module_clock_en)
        else $error("register block disagrees with clock gate");
    mux_gate_a: assert property (comp_mux_allowed == module_clock_en[GATE_CONVERTER_POS])
        else $error("comparator mux allowed while converter gated");
    adc_keep_a: assert property ($past(cfg.adc_enabled) |-> pwr.adc_on)
        else $error("enabled converter switched off");
    wdog_keep_a: assert property ($past(cfg.watchdog_on) |-> pwr.watchdog_on)
        else $error("enabled watchdog stopped");
    osc_keep_a: assert property ($past(cfg.debug_enable_fuse) |-> pwr.main_osc_on)
        else $error("main clock stopped while debugging");
    ref_keep_a: assert property ($past(cfg.comp_uses_ref || cfg.adc_enabled)
        |-> pwr.reference_on) else $error("reference off while needed");
    wake_pins_a: assert property ((pin_buffer_en & $past(wake_pin_mask))
        == $past(wake_pin_mask)) else $error("wake pin buffer disabled");
endmodule
bind sleep_power_ctrl sleep_power_chk #(.NUM_PINS(NUM_PINS)) chk (
    .core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata), .cfg(cfg),
    .wake_pin_mask(wake_pin_mask), .pwr(pwr), .module_clock_en(module_clock_en),
    .module_io_block(module_io_block), .comp_mux_allowed(comp_mux_allowed),
    .pin_buffer_en(pin_buffer_en));
`default_nettype wire
